/* wfm_matcher.sv */
module wfm_matcher #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic rx_last,
  input wire logic [7:0] rx_data,
  input wire logic [47:0] station_mac,
  output logic [wfm_pkg::NUM_PATTERNS-1:0] pattern_match,
  output logic remote_wake_match,
  output logic wake_pending
);

  localparam int NP = wfm_pkg::NUM_PATTERNS;
  localparam int NW = wfm_pkg::MASK_WORDS;
  localparam int RW = wfm_pkg::REG_W;

  // Expected CRC halves and masks, one set per pattern
  logic [RW-1:0] crc_low_reg [NP];
  logic [RW-1:0] crc_high_reg [NP];
  logic [RW-1:0] mask_reg [NP][NW];
  logic [RW-1:0] ctrl_reg;
  logic [RW-1:0] status_reg;

  logic aw_held_reg;
  logic [wfm_pkg::IDX_W-1:0] aw_idx_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  logic aw_take;
  logic w_take;
  logic wr_do;
  logic ar_take;

  logic [NP-1:0] hit_pulse;
  logic magic_pulse;
  logic [RW-1:0] status_set;
  logic [RW-1:0] status_clr;

  wfm_rx_if rx_bus ();

  assign rx_bus.valid = rx_valid;
  assign rx_bus.first = rx_first;
  assign rx_bus.last = rx_last;
  assign rx_bus.data = rx_data;

  function automatic logic wfm_mapped(input logic [wfm_pkg::IDX_W-1:0] idx);
    logic ok;
    ok = (idx == wfm_pkg::WAKE_CTRL_IDX) || (idx == wfm_pkg::WAKE_STATUS_IDX);
    for (int p = 0; p < NP; p++) begin
      ok = ok || (idx == wfm_pkg::CRC_LOW_IDX[p]) || (idx == wfm_pkg::CRC_HIGH_IDX[p]);
      for (int k = 0; k < NW; k++) begin
        ok = ok || (idx == wfm_pkg::MASK_IDX[p][k]);
      end
    end
    return ok;
  endfunction : wfm_mapped

  function automatic logic [RW-1:0] wfm_merge(input logic [RW-1:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
    logic [RW-1:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = data[7:0];
    end
    if (strb[1]) begin
      v[15:8] = data[15:8];
    end
    return v;
  endfunction : wfm_merge

  function automatic logic [RW-1:0] wfm_read(input logic [wfm_pkg::IDX_W-1:0] idx);
    logic [RW-1:0] v;
    v = '0;
    if (idx == wfm_pkg::WAKE_CTRL_IDX) begin
      v = ctrl_reg;
    end
    if (idx == wfm_pkg::WAKE_STATUS_IDX) begin
      v = status_reg;
    end
    for (int p = 0; p < NP; p++) begin
      if (idx == wfm_pkg::CRC_LOW_IDX[p]) begin
        v = crc_low_reg[p];
      end
      if (idx == wfm_pkg::CRC_HIGH_IDX[p]) begin
        v = crc_high_reg[p];
      end
      for (int k = 0; k < NW; k++) begin
        if (idx == wfm_pkg::MASK_IDX[p][k]) begin
          v = mask_reg[p][k];
        end
      end
    end
    return v;
  endfunction : wfm_read

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_do = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // Index kept from the take until the write is applied
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_idx_reg <= '0;
    end else if (aw_take) begin
      aw_idx_reg <= s_axi_awaddr[ADDR_W-1:2];
    end
  end

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held_reg <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end else begin
        if (wr_do) begin
          aw_held_reg <= 1'b0;
        end
        s_axi_awready <= !aw_held_reg && !s_axi_bvalid;
      end
    end
  end

  // Payload held until applied; strobe lanes 2 and 3 are never used
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (w_take) begin
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held_reg <= 1'b0;
    end else begin
      if (w_take) begin
        w_held_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end else begin
        if (wr_do) begin
          w_held_reg <= 1'b0;
        end
        s_axi_wready <= !w_held_reg && !s_axi_bvalid;
      end
    end
  end

  // Unmapped writes are answered but change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= wfm_pkg::AXI_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bresp <= wfm_mapped(aw_idx_reg) ? wfm_pkg::AXI_RESP_OKAY
                                            : wfm_pkg::AXI_RESP_SLVERR;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else begin
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Expected CRC halves, lower half in the first register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < NP; p++) begin
        crc_low_reg[p] <= wfm_pkg::PATTERN_REG_RESET;
        crc_high_reg[p] <= wfm_pkg::PATTERN_REG_RESET;
      end
    end else if (wr_do) begin
      for (int p = 0; p < NP; p++) begin
        if (aw_idx_reg == wfm_pkg::CRC_LOW_IDX[p]) begin
          crc_low_reg[p] <= wfm_merge(crc_low_reg[p], w_data_reg, w_strb_reg);
        end
        if (aw_idx_reg == wfm_pkg::CRC_HIGH_IDX[p]) begin
          crc_high_reg[p] <= wfm_merge(crc_high_reg[p], w_data_reg, w_strb_reg);
        end
      end
    end
  end

  // Byte masks, word k covers frame bytes 16k+1 to 16k+16
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < NP; p++) begin
        for (int k = 0; k < NW; k++) begin
          mask_reg[p][k] <= wfm_pkg::PATTERN_REG_RESET;
        end
      end
    end else if (wr_do) begin
      for (int p = 0; p < NP; p++) begin
        for (int k = 0; k < NW; k++) begin
          if (aw_idx_reg == wfm_pkg::MASK_IDX[p][k]) begin
            mask_reg[p][k] <= wfm_merge(mask_reg[p][k], w_data_reg, w_strb_reg);
          end
        end
      end
    end
  end

  // Enable register; unused bits stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= wfm_pkg::WAKE_CTRL_RESET;
    end else if (wr_do && aw_idx_reg == wfm_pkg::WAKE_CTRL_IDX) begin
      ctrl_reg <= wfm_merge(ctrl_reg, w_data_reg, w_strb_reg)
                  & wfm_pkg::WAKE_CTRL_WMASK;
    end
  end

  // Loaded only on a take, so data and response hold while rvalid waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= wfm_pkg::AXI_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rdata <= {16'h0000, wfm_read(s_axi_araddr[ADDR_W-1:2])};
      s_axi_rresp <= wfm_mapped(s_axi_araddr[ADDR_W-1:2]) ? wfm_pkg::AXI_RESP_OKAY
                                                           : wfm_pkg::AXI_RESP_SLVERR;
    end
  end

  // Read channel, answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else begin
        s_axi_arready <= !s_axi_rvalid;
      end
    end
  end

  // One matcher per pattern, all watching the same frame
  for (genvar p = 0; p < NP; p++) begin : g_pattern
    wfm_pattern_crc u_crc (
      .aclk(aclk),
      .aresetn(aresetn),
      .rx(rx_bus.sink),
      .enable(ctrl_reg[wfm_pkg::PATTERN_ENABLE_LSB + p]),
      .mask({mask_reg[p][3], mask_reg[p][2], mask_reg[p][1], mask_reg[p][0]}),
      .expected({crc_high_reg[p], crc_low_reg[p]}),
      .match(hit_pulse[p])
    );
  end

  wfm_remote_wake u_remote (
    .aclk(aclk),
    .aresetn(aresetn),
    .rx(rx_bus.sink),
    .enable(ctrl_reg[wfm_pkg::REMOTE_WAKE_ENABLE_BIT]),
    .station_mac(station_mac),
    .match(magic_pulse)
  );

  always_comb begin
    status_set = '0;
    status_set[wfm_pkg::PATTERN_HIT_LSB +: NP] = hit_pulse;
    status_set[wfm_pkg::REMOTE_WAKE_HIT_BIT] = magic_pulse;
    status_clr = '0;
    if (wr_do && aw_idx_reg == wfm_pkg::WAKE_STATUS_IDX) begin
      status_clr = wfm_merge('0, w_data_reg, w_strb_reg);
    end
  end

  // Sticky hits, write one to clear; a new hit outranks the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~status_clr) | status_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pattern_match <= '0;
    end else begin
      pattern_match <= hit_pulse;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_wake_match <= 1'b0;
    end else begin
      remote_wake_match <= magic_pulse;
    end
  end

  // Tracks the status next value so it rises with the match pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_pending <= 1'b0;
    end else begin
      wake_pending <= |((status_reg & ~status_clr) | status_set);
    end
  end

endmodule : wfm_matcher

/* wfm_pkg.sv */
// Overview of operation
// - Each pattern runs an Ethernet CRC-32 over only the frame bytes its mask selects.
// - Expected CRC is two 16-bit registers, lower half first, upper half second.
// - First mask register bit 0 selects frame byte 1, bit 15 byte 16.
// - Second mask register bits 0..15 select frame bytes 17 through 32.
// - Third mask register bits 0..15 select frame bytes 33 through 48.
// - Fourth mask register bits 0..15 select frame bytes 49 through 64.
// - Every pattern has its own CRC and masks, matched independently on one frame.
// - Each pattern has an enable bit; cleared means that pattern is ignored.
// - A separate enable bit turns on remote-wake detection of six 0xFF bytes followed by sixteen copies of the station MAC.
package wfm_pkg;

  localparam int NUM_PATTERNS = 3;
  localparam int MASK_WORDS = 4;
  localparam int REG_W = 16;
  localparam int IDX_W = 10;
  localparam int WINDOW_BYTES = 64;
  localparam int CNT_W = 7;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] WAKE_CTRL_IDX = 10'h12a;
  localparam logic [IDX_W-1:0] WAKE_STATUS_IDX = 10'h12c;
  localparam logic [IDX_W-1:0] PATTERN0_CRC_LOW_IDX = 10'h130;
  localparam logic [IDX_W-1:0] PATTERN0_CRC_HIGH_IDX = 10'h132;
  localparam logic [IDX_W-1:0] PATTERN0_MASK_BYTES_1_16_IDX = 10'h134;
  localparam logic [IDX_W-1:0] PATTERN0_MASK_BYTES_17_32_IDX = 10'h136;
  localparam logic [IDX_W-1:0] PATTERN0_MASK_BYTES_33_48_IDX = 10'h138;
  localparam logic [IDX_W-1:0] PATTERN0_MASK_BYTES_49_64_IDX = 10'h13a;
  localparam logic [IDX_W-1:0] PATTERN1_CRC_LOW_IDX = 10'h140;
  localparam logic [IDX_W-1:0] PATTERN1_CRC_HIGH_IDX = 10'h142;
  localparam logic [IDX_W-1:0] PATTERN1_MASK_BYTES_1_16_IDX = 10'h144;
  localparam logic [IDX_W-1:0] PATTERN1_MASK_BYTES_17_32_IDX = 10'h146;
  localparam logic [IDX_W-1:0] PATTERN1_MASK_BYTES_33_48_IDX = 10'h148;
  localparam logic [IDX_W-1:0] PATTERN1_MASK_BYTES_49_64_IDX = 10'h14a;
  localparam logic [IDX_W-1:0] PATTERN2_CRC_LOW_IDX = 10'h150;
  localparam logic [IDX_W-1:0] PATTERN2_CRC_HIGH_IDX = 10'h152;
  localparam logic [IDX_W-1:0] PATTERN2_MASK_BYTES_1_16_IDX = 10'h154;
  localparam logic [IDX_W-1:0] PATTERN2_MASK_BYTES_17_32_IDX = 10'h156;
  localparam logic [IDX_W-1:0] PATTERN2_MASK_BYTES_33_48_IDX = 10'h158;
  localparam logic [IDX_W-1:0] PATTERN2_MASK_BYTES_49_64_IDX = 10'h15a;

  localparam logic [IDX_W-1:0] CRC_LOW_IDX [NUM_PATTERNS] = '{
    PATTERN0_CRC_LOW_IDX, PATTERN1_CRC_LOW_IDX, PATTERN2_CRC_LOW_IDX};
  localparam logic [IDX_W-1:0] CRC_HIGH_IDX [NUM_PATTERNS] = '{
    PATTERN0_CRC_HIGH_IDX, PATTERN1_CRC_HIGH_IDX, PATTERN2_CRC_HIGH_IDX};
  localparam logic [IDX_W-1:0] MASK_IDX [NUM_PATTERNS][MASK_WORDS] = '{
    '{PATTERN0_MASK_BYTES_1_16_IDX, PATTERN0_MASK_BYTES_17_32_IDX,
      PATTERN0_MASK_BYTES_33_48_IDX, PATTERN0_MASK_BYTES_49_64_IDX},
    '{PATTERN1_MASK_BYTES_1_16_IDX, PATTERN1_MASK_BYTES_17_32_IDX,
      PATTERN1_MASK_BYTES_33_48_IDX, PATTERN1_MASK_BYTES_49_64_IDX},
    '{PATTERN2_MASK_BYTES_1_16_IDX, PATTERN2_MASK_BYTES_17_32_IDX,
      PATTERN2_MASK_BYTES_33_48_IDX, PATTERN2_MASK_BYTES_49_64_IDX}};

  // Control and status fields
  localparam int PATTERN_ENABLE_LSB = 0;
  localparam int REMOTE_WAKE_ENABLE_BIT = 7;
  localparam int PATTERN_HIT_LSB = 0;
  localparam int REMOTE_WAKE_HIT_BIT = 7;
  localparam logic [REG_W-1:0] WAKE_CTRL_RESET = 16'h0000;
  localparam logic [REG_W-1:0] PATTERN_REG_RESET = 16'h0000;
  localparam logic [REG_W-1:0] WAKE_CTRL_WMASK = 16'h0087;

  localparam logic [31:0] CRC_POLY_REFLECTED = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

  localparam int MAGIC_SYNC_BYTES = 6;
  localparam int MAGIC_REPEATS = 16;
  localparam int MAC_BYTES = 6;
  localparam logic [7:0] MAGIC_SYNC_VALUE = 8'hff;

  typedef enum logic [1:0] {
    WFM_SCAN_IDLE,
    WFM_SCAN_WINDOW,
    WFM_SCAN_TAIL
  } wfm_scan_t;

  // Reflected CRC-32, one byte, LSB of the byte first as on the wire
  function automatic logic [31:0] wfm_crc32_byte(input logic [31:0] crc,
                                                 input logic [7:0] data);
    logic [31:0] c;
    c = crc ^ {24'h000000, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REFLECTED) : (c >> 1);
    end
    return c;
  endfunction : wfm_crc32_byte

endpackage : wfm_pkg

/* wfm_rx_if.sv */
interface wfm_rx_if;
  logic valid;
  logic first;
  logic last;
  logic [7:0] data;

  modport source (output valid, output first, output last, output data);
  modport sink (input valid, input first, input last, input data);
endinterface : wfm_rx_if

/* wfm_pattern_crc.sv */
module wfm_pattern_crc (
  input wire logic aclk,
  input wire logic aresetn,
  wfm_rx_if.sink rx,
  input wire logic enable,
  input wire logic [wfm_pkg::WINDOW_BYTES-1:0] mask,
  input wire logic [31:0] expected,
  output logic match
);

  wfm_pkg::wfm_scan_t scan_reg;
  logic [wfm_pkg::CNT_W-1:0] count_reg;
  logic [31:0] crc_reg;

  logic [wfm_pkg::CNT_W-1:0] pos;
  logic [wfm_pkg::CNT_W-1:0] len;
  logic active;
  logic in_window;
  logic [31:0] crc_base;
  logic [31:0] crc_next;
  logic covered;

  always_comb begin
    pos = rx.first ? '0 : count_reg;
    active = rx.valid && (rx.first || scan_reg != wfm_pkg::WFM_SCAN_IDLE);
    in_window = active && (pos < 7'h40);
    crc_base = rx.first ? wfm_pkg::CRC_INIT : crc_reg;
    crc_next = crc_base;
    if (in_window && mask[pos[5:0]]) begin
      crc_next = wfm_pkg::wfm_crc32_byte(crc_base, rx.data);
    end
    len = in_window ? pos + 7'h01 : pos;
    // No selected byte may lie beyond the last received byte
    covered = (len >= 7'h40) || ((mask >> len) == '0);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_reg <= wfm_pkg::WFM_SCAN_IDLE;
      count_reg <= '0;
      crc_reg <= wfm_pkg::CRC_INIT;
      match <= 1'b0;
    end else begin
      match <= 1'b0;
      if (active) begin
        crc_reg <= crc_next;
        count_reg <= len;
        if (rx.last) begin
          scan_reg <= wfm_pkg::WFM_SCAN_IDLE;
          match <= enable && covered && (~crc_next == expected);
        end else begin
          case (scan_reg)
            wfm_pkg::WFM_SCAN_IDLE,
            wfm_pkg::WFM_SCAN_WINDOW: begin
              scan_reg <= (len >= 7'h40) ? wfm_pkg::WFM_SCAN_TAIL
                                         : wfm_pkg::WFM_SCAN_WINDOW;
            end
            wfm_pkg::WFM_SCAN_TAIL: scan_reg <= wfm_pkg::WFM_SCAN_TAIL;
            default: scan_reg <= wfm_pkg::WFM_SCAN_IDLE;
          endcase
        end
      end
    end
  end

endmodule : wfm_pattern_crc

/* wfm_remote_wake.sv */
module wfm_remote_wake (
  input wire logic aclk,
  input wire logic aresetn,
  wfm_rx_if.sink rx,
  input wire logic enable,
  input wire logic [47:0] station_mac,
  output logic match
);

  logic [2:0] sync_reg;
  logic [2:0] byte_reg;
  logic [4:0] rep_reg;
  logic found_reg;
  logic [7:0] want;
  logic is_sync;
  logic hit;
  logic found_next;

  always_comb begin
    want = station_mac[47 - 8*byte_reg -: 8];
    is_sync = (rx.data == wfm_pkg::MAGIC_SYNC_VALUE);
    hit = (sync_reg == 3'(wfm_pkg::MAGIC_SYNC_BYTES)) && (rx.data == want);
    found_next = found_reg && !rx.first;
    if (hit && byte_reg == 3'(wfm_pkg::MAC_BYTES - 1)
        && rep_reg == 5'(wfm_pkg::MAGIC_REPEATS - 1)) begin
      found_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_reg <= '0;
      byte_reg <= '0;
      rep_reg <= '0;
      found_reg <= 1'b0;
      match <= 1'b0;
    end else begin
      match <= 1'b0;
      if (rx.valid) begin
        found_reg <= rx.last ? 1'b0 : found_next;
        if (rx.last) begin
          match <= enable && found_next;
        end
        if (rx.last) begin
          sync_reg <= '0;
          byte_reg <= '0;
          rep_reg <= '0;
        end else if (hit) begin
          if (byte_reg == 3'(wfm_pkg::MAC_BYTES - 1)) begin
            byte_reg <= '0;
            rep_reg <= rep_reg + 5'h01;
          end else begin
            byte_reg <= byte_reg + 3'h1;
          end
        end else begin
          // A stray byte restarts the search; a sync byte may begin a new run
          byte_reg <= '0;
          rep_reg <= '0;
          if (is_sync && (byte_reg == '0) && (rep_reg == '0)
              && sync_reg != 3'(wfm_pkg::MAGIC_SYNC_BYTES)) begin
            sync_reg <= sync_reg + 3'h1;
          end else if (is_sync && byte_reg == '0 && rep_reg == '0) begin
            sync_reg <= sync_reg;
          end else begin
            sync_reg <= is_sync ? 3'h1 : 3'h0;
          end
        end
      end
    end
  end

endmodule : wfm_remote_wake

/* wfm_matcher_monitor.sv */
module wfm_matcher_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic [wfm_pkg::NUM_PATTERNS-1:0] pattern_match,
  input wire logic remote_wake_match,
  input wire logic wake_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  ready_low_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready during response");
  read_latency_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
    else $error("read answer late or upper half set");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  match_cause_a: assert property (
    pattern_match != '0 |-> $past(rx_valid && rx_last, 2))
    else $error("pattern match without frame end");
  wake_cause_a: assert property (
    remote_wake_match |-> $past(rx_valid && rx_last, 2))
    else $error("remote wake without frame end");
  pending_a: assert property (
    pattern_match != '0 || remote_wake_match |-> wake_pending)
    else $error("match without pending flag");
  reset_quiet_a: assert property (
    disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && pattern_match == '0)
    else $error("outputs active after reset");
endmodule : wfm_matcher_monitor
bind wfm_matcher wfm_matcher_monitor i_wfm_matcher_monitor (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_last, .pattern_match,
  .remote_wake_match, .wake_pending);

/* wfm_frame_src.sv */
module wfm_frame_src (
  input wire logic aclk,
  output logic rx_valid,
  output logic rx_first,
  output logic rx_last,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] fr [128];
  initial begin
    {rx_valid, rx_first, rx_last} = 3'b000;
    rx_data = 8'h5a;
  end
  // Idle data inverted so a stale byte never looks valid
  task automatic send(input int len, input int gap);
    for (int i = 0; i < len; i++) begin
      @(posedge aclk);
      {rx_valid, rx_first, rx_last} <= {1'b1, i == 0, i == len - 1};
      rx_data <= fr[i];
      for (int g = 0; g < gap && i < len - 1; g++) begin
        @(posedge aclk);
        {rx_valid, rx_first, rx_last} <= 3'b000;
        rx_data <= ~fr[i];
      end
    end
    @(posedge aclk);
    {rx_valid, rx_first, rx_last} <= 3'b000;
    rx_data <= ~rx_data;
  endtask : send
endmodule : wfm_frame_src

/* tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, rx_valid, rx_first, rx_last, remote_wake_match, wake_pending;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot, pattern_match;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] rx_data;
  logic [47:0] station_mac;
  int err_count;
  int n_checks;
  wfm_matcher i_wfm_matcher (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_valid,
    .rx_first, .rx_last, .rx_data, .station_mac, .pattern_match, .remote_wake_match,
    .wake_pending);
  wfm_frame_src i_wfm_frame_src (.aclk, .rx_valid, .rx_first, .rx_last, .rx_data);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic finish_test();
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic hang(input int n);
    if (n >= 200) begin
      err_count++;
      finish_test();
    end
  endtask : hang
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    hang(n);
  endtask : wr
  task automatic rd_reg(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    hang(n);
  endtask : rd_reg
  function automatic logic [11:0] rix(input int p, input int k);
    return {(k == 0) ? wfm_pkg::CRC_LOW_IDX[p] : (k == 1) ? wfm_pkg::CRC_HIGH_IDX[p] :
      wfm_pkg::MASK_IDX[p][k-2], 2'b00};
  endfunction : rix
  // Bitwise reference, independent of the design's byte function
  function automatic logic [31:0] crc_of(input logic [63:0] m);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 64; i++) begin
      for (int b = 0; b < 8; b++) begin
        if (m[i]) c = (c >> 1) ^ ((c[0] ^ i_wfm_frame_src.fr[i][b]) ? 32'hedb88320 : 32'h0);
      end
    end
    return ~c;
  endfunction : crc_of
  task automatic frame(input int len, input int gap, input logic [2:0] pm, input logic rw);
    i_wfm_frame_src.send(len, gap);
    // Match pulse stands only between the first and second edges after this one
    @(posedge aclk);
    #1;
    chk("pattern_match", pattern_match, pm);
    chk("remote_wake_match", remote_wake_match, rw);
  endtask : frame
  task automatic prog(input int p, input logic [63:0] m, input logic [31:0] c);
    wr(rix(p, 0), c[15:0]);
    wr(rix(p, 1), c[31:16]);
    for (int k = 0; k < 4; k++) wr(rix(p, k + 2), m[k*16 +: 16]);
  endtask : prog
  task automatic t_regs();
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 6; k++) begin
        rd_reg(rix(p, k));
        chk("reset value", rd, 32'h0);
        wr(rix(p, k), 16'ha5c3 ^ 16'(p * 16 + k));
        rd_reg(rix(p, k));
        chk("readback", rd, {16'h0000, 16'ha5c3 ^ 16'(p * 16 + k)});
      end
    end
    wr(12'h4f0, 16'hffff);
    chk("unmapped bresp", rsp, wfm_pkg::AXI_RESP_SLVERR);
    rd_reg(12'h4f0);
    chk("unmapped rresp", rsp, wfm_pkg::AXI_RESP_SLVERR);
  endtask : t_regs
  task automatic t_frames();
    logic [63:0] m0;
    logic [63:0] m1;
    int pos [5] = '{0, 15, 16, 47, 63};
    m0 = 64'h8000_8000_0001_8001;
    m1 = 64'h0001_0000_0000_0002;
    for (int i = 0; i < 64; i++) i_wfm_frame_src.fr[i] = 8'(i * 37 + 11);
    prog(0, m0, crc_of(m0));
    prog(1, m1, crc_of(m1));
    prog(2, m0, crc_of(m0));
    wr(12'h4a8, 16'h0003);
    frame(64, 0, 3'b011, 1'b0);
    rd_reg(12'h4b0);
    chk("wake status", rd, 32'h3);
    chk("wake_pending", wake_pending, 1'b1);
    wr(12'h4b0, 16'h0087);
    wr(12'h4a8, 16'hff07);
    rd_reg(12'h4a8);
    chk("enable bits", rd, 32'h7);
    chk("wake_pending", wake_pending, 1'b0);
    frame(64, 2, 3'b111, 1'b0);
    i_wfm_frame_src.fr[5] = ~i_wfm_frame_src.fr[5];
    frame(64, 0, 3'b111, 1'b0);
    // Each selected edge byte alone must break patterns 0 and 2 only
    foreach (pos[j]) begin
      i_wfm_frame_src.fr[pos[j]] ^= 8'h01;
      frame(64, 0, 3'b010, 1'b0);
      i_wfm_frame_src.fr[pos[j]] ^= 8'h01;
    end
    frame(63, 0, 3'b010, 1'b0);
  endtask : t_frames
  task automatic t_remote();
    for (int i = 0; i < 102; i++) begin
      i_wfm_frame_src.fr[i] = (i < 6) ? 8'hff : station_mac[8 * (5 - (i - 6) % 6) +: 8];
    end
    wr(12'h4a8, 16'h0080);
    frame(102, 1, 3'b000, 1'b1);
    wr(12'h4a8, 16'h0000);
    frame(102, 0, 3'b000, 1'b0);
  endtask : t_remote
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b00000;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    station_mac = 48'h02a1b2c3d4e5;
    err_count = 0;
    n_checks = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_frames();
    t_remote();
    finish_test();
  end
endmodule : tb
